// >>> hdl/bcd_counter_pkg.sv
package bcd_counter_pkg;

    // Register byte offsets
    localparam logic [7:0]  CTRL_OFFSET       = 8'h00;
    localparam logic [7:0]  PRESET_OFFSET     = 8'h04;
    localparam logic [7:0]  COUNT_OFFSET      = 8'h08;
    localparam logic [7:0]  INT_STATUS_OFFSET = 8'h0C;
    localparam logic [7:0]  INT_MASK_OFFSET   = 8'h10;

    // Control register fields
    localparam int          CTRL_RUN_BIT      = 0;
    localparam int          CTRL_SRC_BIT      = 1;
    localparam int          CTRL_CLEAR_BIT    = 2;
    localparam logic [1:0]  CTRL_RESET        = 2'h1;

    // Interrupt status and mask fields
    localparam int          INT_ZERO_BIT      = 0;
    localparam int          INT_LOAD_BIT      = 1;
    localparam int          INT_BAD_BIT       = 2;
    localparam int          INT_WIDTH         = 3;
    localparam logic [2:0]  INT_RESET         = 3'h0;

    // Count register fields
    localparam int          COUNT_ZERO_BIT    = 8;

    // Digit layout and values
    localparam int          DIGIT_WIDTH       = 4;
    localparam int          DIGIT_COUNT       = 2;
    localparam logic [3:0]  DIGIT_MAX         = 4'h9;
    localparam logic [3:0]  DIGIT_ZERO        = 4'h0;
    localparam logic [7:0]  COUNT_MAX         = 8'h99;
    localparam logic [7:0]  COUNT_ZERO        = 8'h00;
    localparam logic [7:0]  PRESET_RESET      = 8'h00;

    // Pin synchroniser layout and reset value (active-low pins idle high)
    localparam int          PIN_WIDTH         = 13;
    localparam int          PIN_CLK_BIT       = 12;
    localparam int          PIN_CLEAR_BIT     = 11;
    localparam int          PIN_ENABLE_BIT    = 10;
    localparam int          PIN_SLOAD_BIT     = 9;
    localparam int          PIN_ALOAD_BIT     = 8;
    localparam logic [12:0] PIN_RESET         = 13'h0F00;

endpackage

// >>> hdl/bcd_digit_step.sv
`timescale 1ns/100ps

module bcd_digit_step
(
    // Current digit and borrow from the lower digit
    input  wire logic [3:0] digit_in,
    input  wire logic       borrow_in,
    // Next digit and borrow to the higher digit
    output logic      [3:0] digit_next,
    output logic            borrow_out,
    output logic            digit_bad
);

    always_comb
    begin
        digit_bad  = (digit_in > bcd_counter_pkg::DIGIT_MAX);
        borrow_out = borrow_in && (digit_in == bcd_counter_pkg::DIGIT_ZERO);
        if (!borrow_in)
        begin
            digit_next = digit_in;
        end
        else if (digit_in == bcd_counter_pkg::DIGIT_ZERO)
        begin
            // Wrapping through zero gives 9, so 00 steps to 99
            digit_next = bcd_counter_pkg::DIGIT_MAX;
        end
        else
        begin
            // Non-decimal codes simply step down in binary
            digit_next = digit_in - 4'h1;
        end
    end

endmodule // bcd_digit_step

// >>> hdl/bcd_down_counter_two_digit.sv
`timescale 1ns/100ps


module bcd_down_counter_two_digit
(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Counter pins
    input  wire logic        count_clock,
    input  wire logic        master_clear_n,
    input  wire logic        count_enable_n,
    input  wire logic        sync_load_n,
    input  wire logic        async_load_n,
    input  wire logic [7:0]  preset_value,
    output logic             zero_count_n,
    output logic      [3:0]  tens_digit,
    output logic      [3:0]  units_digit,
    // Interrupt
    output logic             irq
);

    // Pin synchroniser: stage one is read only by stage two
    logic [12:0] pin_meta;
    logic [12:0] pin_sync;
    logic        clk_prev;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_meta <= bcd_counter_pkg::PIN_RESET;
            pin_sync <= bcd_counter_pkg::PIN_RESET;
            clk_prev <= 1'b0;
        end
        else
        begin
            pin_meta <= {count_clock, master_clear_n, count_enable_n, sync_load_n,
                         async_load_n, preset_value};
            pin_sync <= pin_meta;
            clk_prev <= pin_sync[bcd_counter_pkg::PIN_CLK_BIT];
        end
    end

    logic       count_edge;
    logic       clear_n_s;
    logic       enable_n_s;
    logic       sload_n_s;
    logic       aload_n_s;
    logic [7:0] preset_pins;

    // Controls are active low throughout
    assign count_edge  = pin_sync[bcd_counter_pkg::PIN_CLK_BIT] && !clk_prev;
    assign clear_n_s   = pin_sync[bcd_counter_pkg::PIN_CLEAR_BIT];
    assign enable_n_s  = pin_sync[bcd_counter_pkg::PIN_ENABLE_BIT];
    assign sload_n_s   = pin_sync[bcd_counter_pkg::PIN_SLOAD_BIT];
    assign aload_n_s   = pin_sync[bcd_counter_pkg::PIN_ALOAD_BIT];
    assign preset_pins = pin_sync[7:0];

    // Registers
    logic [7:0]  count;
    logic [1:0]  ctrl;
    logic [7:0]  preset_reg;
    logic [2:0]  int_status;
    logic [2:0]  int_mask;

    logic [7:0]  next_count;
    logic [1:0]  next_ctrl;
    logic [7:0]  next_preset_reg;
    logic [2:0]  next_int_status;
    logic [2:0]  next_int_mask;
    logic        next_zero_count_n;
    logic        next_irq;
    logic [31:0] next_prdata;
    logic        next_pready;
    logic        next_pslverr;

    // Digit stepping, one stage per digit
    logic [7:0] stepped;
    logic [2:0] borrow;
    logic [1:0] preset_bad;
    logic [7:0] preset_sel;

    // Register preset can replace the pins when software selects it
    assign preset_sel = ctrl[bcd_counter_pkg::CTRL_SRC_BIT] ? preset_reg : preset_pins;
    assign borrow[0]  = 1'b1;

    genvar g;
    generate
        for (g = 0; g < bcd_counter_pkg::DIGIT_COUNT; g = g + 1)
        begin : gen_digit
            // Digit 0 is units, digit 1 tens; borrow cascades upward
            bcd_digit_step u_step
            (
                .digit_in   (count[g*4 +: 4]),
                .borrow_in  (borrow[g]),
                .digit_next (stepped[g*4 +: 4]),
                .borrow_out (borrow[g+1]),
                .digit_bad  ()
            );
            assign preset_bad[g] = (preset_sel[g*4 +: 4] > bcd_counter_pkg::DIGIT_MAX);
        end
    endgenerate

    // APB decode
    logic       apb_setup_done;
    logic       apb_write;
    logic       sw_clear;
    logic       addr_hit;

    assign apb_setup_done = psel && penable && !pready;
    assign apb_write      = psel && penable && pready && pwrite;

    always_comb
    begin
        addr_hit = 1'b0;
        if (paddr == bcd_counter_pkg::CTRL_OFFSET)
        begin
            addr_hit = 1'b1;
        end
        else if (paddr == bcd_counter_pkg::PRESET_OFFSET)
        begin
            addr_hit = 1'b1;
        end
        else if (paddr == bcd_counter_pkg::COUNT_OFFSET)
        begin
            addr_hit = 1'b1;
        end
        else if (paddr == bcd_counter_pkg::INT_STATUS_OFFSET)
        begin
            addr_hit = 1'b1;
        end
        else if (paddr == bcd_counter_pkg::INT_MASK_OFFSET)
        begin
            addr_hit = 1'b1;
        end
    end

    assign sw_clear = apb_write && (paddr == bcd_counter_pkg::CTRL_OFFSET)
                      && pwdata[bcd_counter_pkg::CTRL_CLEAR_BIT];

    // Counter next state
    logic load_now;
    logic counting;

    always_comb
    begin
        next_count = count;
        load_now   = 1'b0;
        counting   = 1'b0;
        if (!clear_n_s || sw_clear)
        begin
            next_count = bcd_counter_pkg::COUNT_MAX;
        end
        else if (!aload_n_s)
        begin
            // Applied on every cycle it is low, whether or not the count clock moves
            next_count = preset_sel;
            load_now   = 1'b1;
        end
        else if (count_edge && !sload_n_s)
        begin
            next_count = preset_sel;
            load_now   = 1'b1;
        end
        else if (count_edge && !enable_n_s && ctrl[bcd_counter_pkg::CTRL_RUN_BIT])
        begin
            next_count = stepped;
            counting   = 1'b1;
        end
        // Otherwise the count holds
    end

    // Zero-count decode tracks enable on every pclk, not on count edges
    always_comb
    begin
        next_zero_count_n = !((next_count == bcd_counter_pkg::COUNT_ZERO) && !enable_n_s);
    end

    // Register writes and interrupt status; a set beats a same-cycle clear
    logic [2:0] events;

    always_comb
    begin
        events                              = 3'h0;
        events[bcd_counter_pkg::INT_ZERO_BIT] = zero_count_n && !next_zero_count_n;
        events[bcd_counter_pkg::INT_LOAD_BIT] = load_now && !(load_now && aload_n_s == 1'b0
                                                 && count == preset_sel);
        events[bcd_counter_pkg::INT_BAD_BIT]  = load_now && (preset_bad != 2'h0);

        next_ctrl       = ctrl;
        next_preset_reg = preset_reg;
        next_int_mask   = int_mask;
        next_int_status = int_status | events;
        if (apb_write)
        begin
            if (paddr == bcd_counter_pkg::CTRL_OFFSET)
            begin
                next_ctrl = pwdata[1:0];
            end
            else if (paddr == bcd_counter_pkg::PRESET_OFFSET)
            begin
                next_preset_reg = pwdata[7:0];
            end
            else if (paddr == bcd_counter_pkg::INT_STATUS_OFFSET)
            begin
                next_int_status = (int_status & ~pwdata[2:0]) | events;
            end
            else if (paddr == bcd_counter_pkg::INT_MASK_OFFSET)
            begin
                next_int_mask = pwdata[2:0];
            end
        end
        next_irq = ((next_int_status & next_int_mask) != 3'h0);
    end

    // APB answer: one wait state, data captured in the first access cycle
    always_comb
    begin
        next_pready  = apb_setup_done;
        next_pslverr = apb_setup_done && !addr_hit;
        next_prdata  = prdata;
        if (apb_setup_done)
        begin
            next_prdata = 32'h0;
            if (pwrite)
            begin
                next_prdata = 32'h0;
            end
            else if (paddr == bcd_counter_pkg::CTRL_OFFSET)
            begin
                next_prdata[1:0] = ctrl;
            end
            else if (paddr == bcd_counter_pkg::PRESET_OFFSET)
            begin
                next_prdata[7:0] = preset_reg;
            end
            else if (paddr == bcd_counter_pkg::COUNT_OFFSET)
            begin
                next_prdata[7:0] = count;
                next_prdata[bcd_counter_pkg::COUNT_ZERO_BIT] = !zero_count_n;
            end
            else if (paddr == bcd_counter_pkg::INT_STATUS_OFFSET)
            begin
                next_prdata[2:0] = int_status;
            end
            else if (paddr == bcd_counter_pkg::INT_MASK_OFFSET)
            begin
                next_prdata[2:0] = int_mask;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            count        <= bcd_counter_pkg::COUNT_MAX;
            ctrl         <= bcd_counter_pkg::CTRL_RESET;
            preset_reg   <= bcd_counter_pkg::PRESET_RESET;
            int_status   <= bcd_counter_pkg::INT_RESET;
            int_mask     <= bcd_counter_pkg::INT_RESET;
            zero_count_n <= 1'b1;
            irq          <= 1'b0;
            prdata       <= 32'h0;
            pready       <= 1'b0;
            pslverr      <= 1'b0;
        end
        else
        begin
            count        <= next_count;
            ctrl         <= next_ctrl;
            preset_reg   <= next_preset_reg;
            int_status   <= next_int_status;
            int_mask     <= next_int_mask;
            zero_count_n <= next_zero_count_n;
            irq          <= next_irq;
            prdata       <= next_prdata;
            pready       <= next_pready;
            pslverr      <= next_pslverr;
        end
    end

    // Digit pins mirror the count register directly
    assign tens_digit  = count[7:4];
    assign units_digit = count[3:0];

endmodule // bcd_down_counter_two_digit

// >>> sim/bcd_counter_assertions.sv
`timescale 1ns/100ps

module bcd_counter_checker
(
    // Clock, reset and bus handshake
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic       psel,
    input wire logic       penable,
    input wire logic       pready,
    // Counter pins
    input wire logic       count_clock,
    input wire logic       master_clear_n,
    input wire logic       count_enable_n,
    input wire logic       sync_load_n,
    input wire logic       async_load_n,
    input wire logic [7:0] preset_value,
    input wire logic       zero_count_n,
    input wire logic [3:0] tens_digit,
    input wire logic [3:0] units_digit
);
    logic [7:0] cnt;
    logic       quiet;
    assign cnt   = {tens_digit, units_digit};
    // Bus writes may clear the count, so they count as activity
    assign quiet = sync_load_n && async_load_n && master_clear_n && !psel;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    function automatic logic [7:0] dec(input logic [7:0] v);
        if (v[3:0] != 4'h0)
            return v - 8'h01;
        return (v[7:4] == 4'h0) ? 8'h99 : {v[7:4] - 4'h1, 4'h9};
    endfunction
    sequence rise_s;
        $rose(count_clock);
    endsequence
    sequence sload_s;
        !sync_load_n && async_load_n && master_clear_n && !psel && $stable(preset_value);
    endsequence
    a_clear_max: assert property (!master_clear_n[*3] |=> cnt == 8'h99)
        else $error("count not at maximum after clear");
    a_count_step: assert property (quiet[*6] ##1 (cnt != $past(cnt)) |-> cnt == dec($past(cnt)))
        else $error("count did not step down by one");
    a_count_hold: assert property ((quiet && count_enable_n)[*6] |=> $stable(cnt))
        else $error("count moved while disabled");
    a_async_load: assert property ((!async_load_n && master_clear_n && !psel && $stable(preset_value))[*4] |=> cnt == $past(preset_value))
        else $error("async load did not force preset");
    a_sync_load: assert property (rise_s ##0 sload_s ##1 sload_s[*2] |=> cnt == $past(preset_value))
        else $error("sync load did not capture preset");
    a_zero_only: assert property (!zero_count_n |-> cnt == 8'h00)
        else $error("zero output active at nonzero count");
    a_zero_follow: assert property ((cnt == 8'h00 && !count_enable_n)[*4] |-> !zero_count_n)
        else $error("zero output missing at zero count");
    a_ready_wait: assert property ($rose(penable) && psel |=> pready)
        else $error("ready not after one wait state");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
endmodule // bcd_counter_checker

bind bcd_down_counter_two_digit bcd_counter_checker u_chk (.pclk, .presetn, .psel, .penable,
    .pready, .count_clock, .master_clear_n, .count_enable_n, .sync_load_n, .async_load_n,
    .preset_value, .zero_count_n, .tens_digit, .units_digit);

// >>> sim/count_pin_driver.sv
`timescale 1ns/100ps

module count_pin_driver
(
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Pulse request and chained zero output
    input  wire logic run,
    input  wire logic zero_count_n,
    // Count clock and cascaded stage tally
    output logic       count_clock,
    output logic [7:0] wraps
);
    logic [1:0] phase;
    logic       zero_q;
    // Each level lasts 4 pclk, past the pin filter; the clock parks low when idle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            phase       <= 2'h0;
            count_clock <= 1'b0;
            zero_q      <= 1'b1;
            wraps       <= 8'h00;
        end
        else
        begin
            phase  <= (run || count_clock) ? phase + 2'h1 : 2'h0;
            zero_q <= zero_count_n;
            if (phase == 2'h3)
                count_clock <= !count_clock && run;
            if (zero_q && !zero_count_n)
                wraps <= wraps + 8'h01;
        end
    end
endmodule // count_pin_driver

// >>> sim/tb_bcd_down_counter_two_digit.sv
`timescale 1ns/100ps

`define CHK(got, exp) \
    begin \
        n_checks++; \
        if ((got) !== (exp)) \
        begin \
            errors++; \
            $display("unexpected at %0t: got %h expected %h", $time, got, exp); \
        end \
    end

module tb_bcd_down_counter_two_digit;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err, run, irq;
    logic        count_clock, master_clear_n, count_enable_n, sync_load_n, async_load_n;
    logic        zero_count_n;
    logic [3:0]  tens_digit, units_digit;
    logic [7:0]  paddr, preset_value, exp_cnt, wraps;
    logic [31:0] pwdata, prdata, rd;
    int          errors, n_checks;

    initial pclk = 1'b0;
    always #4 pclk = ~pclk;

    bcd_down_counter_two_digit dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .count_clock, .master_clear_n,
        .count_enable_n, .sync_load_n, .async_load_n, .preset_value, .zero_count_n,
        .tens_digit, .units_digit, .irq);
    count_pin_driver partner (.pclk, .presetn, .run, .zero_count_n, .count_clock, .wraps);

    function automatic logic [7:0] dec(input logic [7:0] v);
        if (v[3:0] != 4'h0)
            return v - 8'h01;
        return (v[7:4] == 4'h0) ? 8'h99 : {v[7:4] - 4'h1, 4'h9};
    endfunction

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Waits for the next count change, then compares it
    task automatic step(input logic [7:0] e);
        logic [7:0] c;
        c = {tens_digit, units_digit};
        for (int i = 0; i < 40 && {tens_digit, units_digit} === c; i++)
            @(posedge pclk);
        `CHK({tens_digit, units_digit}, e)
    endtask

    task automatic final_report();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial
    begin
        repeat (5000) @(posedge pclk);
        errors++;
        final_report();
    end

    initial
    begin
        {psel, penable, pwrite, run, presetn} = 5'h00;
        {master_clear_n, count_enable_n, sync_load_n, async_load_n} = 4'hF;
        {paddr, preset_value, pwdata} = 48'h0;
        void'($urandom(32'hF4DD));
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        `CHK({zero_count_n, tens_digit, units_digit}, 9'h199)
        apb(1'b0, 8'h14, 32'h0);
        `CHK({err, rd}, 33'h100000000)
        apb(1'b1, bcd_counter_pkg::INT_MASK_OFFSET, 32'h0);
        repeat (4)
        begin
            exp_cnt = {4'($urandom % 10), 4'($urandom % 10)};
            preset_value <= exp_cnt;
            async_load_n <= 1'b0;
            repeat (6) @(posedge pclk);
            `CHK({tens_digit, units_digit}, exp_cnt)
        end
        // Clear must win over a load that is still held
        master_clear_n <= 1'b0;
        repeat (6) @(posedge pclk);
        `CHK({tens_digit, units_digit}, 8'h99)
        master_clear_n <= 1'b1;
        preset_value <= 8'h02;
        repeat (6) @(posedge pclk);
        async_load_n <= 1'b1;
        count_enable_n <= 1'b0;
        run <= 1'b1;
        step(8'h01);
        step(8'h00);
        `CHK(zero_count_n, 1'b0)
        step(8'h99);
        step(8'h98);
        count_enable_n <= 1'b1;
        repeat (30) @(posedge pclk);
        `CHK({tens_digit, units_digit, wraps}, 16'h9801)
        `CHK(irq, 1'b0)
        apb(1'b1, bcd_counter_pkg::INT_MASK_OFFSET, 32'h1);
        repeat (2) @(posedge pclk);
        `CHK(irq, 1'b1)
        apb(1'b1, bcd_counter_pkg::INT_STATUS_OFFSET, 32'h7);
        apb(1'b0, bcd_counter_pkg::INT_STATUS_OFFSET, 32'h0);
        `CHK({irq, rd}, 33'h0)
        apb(1'b1, bcd_counter_pkg::CTRL_OFFSET, 32'h5);
        repeat (4) @(posedge pclk);
        apb(1'b0, bcd_counter_pkg::COUNT_OFFSET, 32'h0);
        `CHK(rd, 32'h99)
        exp_cnt = {4'($urandom % 9), 4'($urandom % 10)};
        preset_value <= exp_cnt;
        sync_load_n <= 1'b0;
        step(exp_cnt);
        sync_load_n <= 1'b1;
        count_enable_n <= 1'b0;
        // Expected sequence runs on from the loaded preset, not from the outputs
        repeat (12)
        begin
            exp_cnt = dec(exp_cnt);
            step(exp_cnt);
        end
        run <= 1'b0;
        final_report();
    end
endmodule // tb_bcd_down_counter_two_digit
